// ===== src/fao_pkg.sv
package fao_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int CODE_W = 4;
  localparam int EVT_W = 4;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 4'hc;

  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'h1;
  localparam logic [EVT_W-1:0] MASK_RST = 4'h0;

  localparam int EVT_LOAD = 0;
  localparam int EVT_CHANGE = 1;
  localparam int EVT_OVER = 2;
  localparam int EVT_STANDBY = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_PERIOD_NS = 40;
  localparam int STANDBY_MAX_NS = 5000;
  localparam int STANDBY_CYC = STANDBY_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic {
    PH_BALANCE = 1'b0,
    PH_SAMPLE = 1'b1
  } fao_phase_t;

  typedef struct packed {
    logic ovr;
    logic [CODE_W-1:0] code;
  } fao_conv_t;

  typedef struct packed {
    logic chg;
    logic ovr;
    logic [CODE_W-1:0] code;
  } fao_result_t;
endpackage

// ===== src/fao_quant.sv
`timescale 1ns/1ps
module fao_quant #(
  parameter int VW = 8
) (
  input wire logic [VW-1:0] vin_i,
  output fao_pkg::fao_conv_t conv_o
);
  localparam int NCMP = 16;
  logic [NCMP-1:0] therm;

  // tap n sits at (2n-1)/32 of span: codes centred on whole steps
  genvar g;
  generate
    for (g = 1; g <= NCMP; g++) begin : g_cmp
      localparam logic [VW:0] TAP = (VW+1)'((2 * g - 1) << (VW - 5));
      assign therm[g-1] = {1'b0, vin_i} >= TAP;
    end
  endgenerate

  always_comb begin
    logic [fao_pkg::CODE_W:0] cnt;
    cnt = '0;
    for (int i = 0; i < NCMP - 1; i++) begin
      cnt = cnt + {{fao_pkg::CODE_W{1'b0}}, therm[i]};
    end
    conv_o.code = cnt[fao_pkg::CODE_W-1:0];
    conv_o.ovr = therm[NCMP-1]; // code already all ones here
  end
endmodule

// ===== src/fao_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module fao_top #(
  parameter int VW = 8,
  parameter int STANDBY_CYC = fao_pkg::STANDBY_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sclk_pin_i,
  input wire logic [VW-1:0] vin_i,
  input wire logic code_bits_enable_n_i,
  input wire logic master_output_enable_i,
  output logic [fao_pkg::CODE_W-1:0] code_bit_o,
  output logic code_bit_oe_n_o,
  output logic result_changed_flag_o,
  output logic range_exceeded_flag_o,
  output logic flag_oe_n_o,
  output logic irq_o,
  input wire logic [fao_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fao_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fao_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fao_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int EW = fao_pkg::EVT_W;
  localparam int CW = $clog2(STANDBY_CYC + 1);
  localparam logic [CW-1:0] STBY_LIM = CW'(STANDBY_CYC);

  // pin synchronisers; vin is assumed steady around the clock fall
  logic [1:0] sclk_sy_r, ben_sy_r, men_sy_r;
  logic [VW-1:0] vin_s1_r, vin_s2_r;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_sy_r <= '0;
      ben_sy_r <= 2'h3;
      men_sy_r <= '0;
      vin_s1_r <= '0;
      vin_s2_r <= '0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[0], sclk_pin_i};
      ben_sy_r <= {ben_sy_r[0], code_bits_enable_n_i};
      men_sy_r <= {men_sy_r[0], master_output_enable_i};
      vin_s1_r <= vin_i;
      vin_s2_r <= vin_s1_r;
    end
  end

  fao_pkg::fao_conv_t quant;
  fao_quant #(.VW(VW)) u_quant (
    .vin_i(vin_s2_r),
    .conv_o(quant)
  );

  // conversion datapath
  fao_pkg::fao_phase_t phase_r, phase_nxt;
  fao_pkg::fao_conv_t latch_r, latch_nxt;
  fao_pkg::fao_result_t out_r, out_nxt;
  logic code_oe_n_r, code_oe_n_nxt, flag_oe_n_r, flag_oe_n_nxt;
  logic [CW-1:0] stby_cnt_r, stby_cnt_nxt;
  logic run;
  logic fall, rise, stby_evt;
  logic [EW-1:0] evt;

  always_comb begin
    phase_nxt = sclk_sy_r[1] ? fao_pkg::PH_SAMPLE : fao_pkg::PH_BALANCE;
    fall = (phase_r == fao_pkg::PH_SAMPLE) && !sclk_sy_r[1];
    rise = (phase_r == fao_pkg::PH_BALANCE) && sclk_sy_r[1];
    latch_nxt = latch_r;
    out_nxt = out_r;
    evt = '0;
    if (run && fall) begin
      latch_nxt = quant;
    end
    // each rise loads whatever the last fall caught, so a double pulse
    // from either standby yields one fresh result
    if (run && rise) begin
      out_nxt.code = latch_r.code;
      out_nxt.ovr = latch_r.ovr;
      out_nxt.chg = (latch_r != {out_r.ovr, out_r.code});
      evt[fao_pkg::EVT_LOAD] = 1'b1;
      evt[fao_pkg::EVT_CHANGE] = out_nxt.chg;
      evt[fao_pkg::EVT_OVER] = latch_r.ovr;
    end
    // indefinite sample standby is legal, only flagged as droop hazard
    stby_evt = 1'b0;
    stby_cnt_nxt = '0;
    if (run && phase_r == fao_pkg::PH_SAMPLE && !fall) begin
      if (stby_cnt_r < STBY_LIM) begin
        stby_cnt_nxt = stby_cnt_r + 1'b1;
        stby_evt = (stby_cnt_r == STBY_LIM - 1'b1);
      end else begin
        stby_cnt_nxt = stby_cnt_r;
      end
    end
    evt[fao_pkg::EVT_STANDBY] = stby_evt;
    // stored result untouched by enables
    code_oe_n_nxt = !(men_sy_r[1] && !ben_sy_r[1]);
    flag_oe_n_nxt = !men_sy_r[1];
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= fao_pkg::PH_BALANCE;
      latch_r <= '0;
      out_r <= '0;
      code_oe_n_r <= 1'b1;
      flag_oe_n_r <= 1'b1;
      stby_cnt_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      latch_r <= latch_nxt;
      out_r <= out_nxt;
      code_oe_n_r <= code_oe_n_nxt;
      flag_oe_n_r <= flag_oe_n_nxt;
      stby_cnt_r <= stby_cnt_nxt;
    end
  end

  assign code_bit_o = out_r.code;
  assign result_changed_flag_o = out_r.chg;
  assign range_exceeded_flag_o = out_r.ovr;
  assign code_bit_oe_n_o = code_oe_n_r;
  assign flag_oe_n_o = flag_oe_n_r;

  // register slave
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [fao_pkg::ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [fao_pkg::DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic ctrl_r, ctrl_nxt;
  logic [EW-1:0] status_r, status_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic do_wr;
  logic [EW-1:0] w1c;

  assign run = ctrl_r;

  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    w1c = '0;
    if (s_axi_awvalid && awready_r) begin
      awready_nxt = 1'b0;
      waddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      wready_nxt = 1'b0;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    do_wr = !awready_r && !wready_r && !bvalid_r;
    if (do_wr) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = fao_pkg::RESP_OKAY;
      if (waddr_r == fao_pkg::OFS_CTRL) begin
        if (wstrb_r[0]) ctrl_nxt = wdata_r[fao_pkg::CTRL_RUN_BIT];
      end else if (waddr_r == fao_pkg::OFS_STATUS) begin
        if (wstrb_r[0]) w1c = wdata_r[EW-1:0];
      end else if (waddr_r == fao_pkg::OFS_MASK) begin
        if (wstrb_r[0]) mask_nxt = wdata_r[EW-1:0];
      end else if (waddr_r == fao_pkg::OFS_RESULT) begin
        bresp_nxt = fao_pkg::RESP_OKAY;
      end else begin
        bresp_nxt = fao_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    // a new event beats a clear in the same cycle
    status_nxt = (status_r & ~w1c) | evt;
    irq_nxt = |(status_nxt & mask_nxt);

    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = fao_pkg::RESP_OKAY;
      rdata_nxt = '0;
      if (s_axi_araddr == fao_pkg::OFS_CTRL) begin
        rdata_nxt[fao_pkg::CTRL_RUN_BIT] = ctrl_r;
      end else if (s_axi_araddr == fao_pkg::OFS_STATUS) begin
        rdata_nxt[EW-1:0] = status_r;
      end else if (s_axi_araddr == fao_pkg::OFS_MASK) begin
        rdata_nxt[EW-1:0] = mask_r;
      end else if (s_axi_araddr == fao_pkg::OFS_RESULT) begin
        rdata_nxt[$bits(fao_pkg::fao_result_t)-1:0] = out_r;
      end else begin
        rresp_nxt = fao_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= fao_pkg::RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= fao_pkg::RESP_OKAY;
      rdata_r <= '0;
      ctrl_r <= fao_pkg::CTRL_RUN_RST;
      status_r <= '0;
      mask_r <= fao_pkg::MASK_RST;
      irq_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign irq_o = irq_r;
endmodule

// ===== src/dummy_unused_none.sv
`timescale 1ns/1ps

// ===== sim/fao_top_props.sv
`timescale 1ns/1ps
module fao_top_props (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sclk_pin_i,
  input wire logic code_bits_enable_n_i,
  input wire logic master_output_enable_i,
  input wire logic [fao_pkg::CODE_W-1:0] code_bit_o,
  input wire logic code_bit_oe_n_o,
  input wire logic result_changed_flag_o,
  input wire logic range_exceeded_flag_o,
  input wire logic flag_oe_n_o,
  input wire logic irq_o,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  wire men = master_output_enable_i;
  wire bn = code_bits_enable_n_i;
  wire [5:0] res = {result_changed_flag_o, range_exceeded_flag_o, code_bit_o};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // five samples leave room for the enable synchroniser
  all_drive_a: assert property ((men && !bn) [*5] |->
    !code_bit_oe_n_o && !flag_oe_n_o) else $error("outputs not driven");
  flags_only_a: assert property ((men && bn) [*5] |->
    code_bit_oe_n_o && !flag_oe_n_o) else $error("bit enable wrong");
  all_float_a: assert property (!men [*5] |->
    code_bit_oe_n_o && flag_oe_n_o) else $error("master enable wrong");
  over_code_a: assert property (range_exceeded_flag_o |->
    code_bit_o == 4'hf) else $error("overflow code not all ones");
  change_flag_a: assert property ($changed(res[4:0]) |->
    res[5]) else $error("change flag low on new result");
  change_rise_a: assert property ($rose(res[5]) |->
    $changed(res[4:0])) else $error("change flag high on same result");
  load_quiet_a: assert property (!sclk_pin_i [*6] |->
    $stable(res)) else $error("result moved without clock rise");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  write_busy_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  cover property ($rose(range_exceeded_flag_o));
  cover property ($rose(result_changed_flag_o));
  cover property ($rose(irq_o));
endmodule

// ===== sim/fao_host.sv
`timescale 1ns/1ps
module fao_host (
  input wire logic mclk_i,
  output logic sclk_o
);
  initial sclk_o = 1'b0;
  // w sets phase length, so the host can be brisk or slow
  task automatic convert(input int mode, input int w);
    logic [3:0] lv;
    case (mode)
      0: lv = 4'b0111; // one balance dip, park in sample
      1: lv = 4'b1010; // two sample pulses, park in balance
      default: lv = 4'b0101; // two dips, park in sample
    endcase
    repeat (w) @(posedge mclk_i);
    for (int k = 3; k >= 0; k--) begin
      sclk_o <= lv[k];
      repeat (w) @(posedge mclk_i);
    end
  endtask
endmodule

// ===== sim/tb_fao_top.sv
`timescale 1ns/1ps
module tb_fao_top;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sclk;
  logic [7:0] vin_i = 8'h00;
  logic bits_n = 1'b0;
  logic men = 1'b1;
  logic [3:0] code_bit_o, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic code_bit_oe_n_o, result_changed_flag_o, range_exceeded_flag_o;
  logic flag_oe_n_o, irq_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] prev, e;
  logic [7:0] vt [8] = '{8'h00, 8'h07, 8'h08, 8'h80, 8'hf7, 8'hf8, 8'hf8,
    8'h80};
  logic [1:0] en [5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
  logic [1:0] ex [5] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h0};
  int mismatches = 0, samples_checked = 0, cyc = 0;
  fao_host host_inst (.mclk_i, .sclk_o(sclk));
  fao_top #(.STANDBY_CYC(8)) fao_top_inst (.mclk_i, .rst_b_i,
    .sclk_pin_i(sclk), .vin_i, .code_bits_enable_n_i(bits_n),
    .master_output_enable_i(men), .code_bit_o, .code_bit_oe_n_o,
    .result_changed_flag_o, .range_exceeded_flag_o, .flag_oe_n_o, .irq_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #20 mclk_i = ~mclk_i;
  function automatic logic [4:0] exp_res(input logic [7:0] v);
    logic [8:0] t;
    t = {1'b0, v} + 9'h008;
    if (v >= 8'hf8) return 5'h1f;
    return {1'b0, t[7:4]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    chk(32'({irq_o, code_bit_oe_n_o, flag_oe_n_o}), 32'h3);
    rd(fao_pkg::OFS_CTRL);
    chk(d, 32'h1);
    chk(32'(r), 32'(fao_pkg::RESP_OKAY));
    rd(fao_pkg::OFS_MASK);
    chk(d, 32'h0);
    $display("reset test done");
    prev = 5'h00;
    for (int i = 0; i < 8; i++) begin
      vin_i <= vt[i];
      host_inst.convert(i % 3, 3 + 3 * (i % 2));
      repeat (6) @(posedge mclk_i);
      e = exp_res(vt[i]);
      chk(32'({result_changed_flag_o, range_exceeded_flag_o, code_bit_o}),
        32'({e != prev, e}));
      rd(fao_pkg::OFS_RESULT);
      chk(d, 32'({e != prev, e}));
      prev = e;
    end
    $display("conversion test done");
    rd(fao_pkg::OFS_STATUS);
    // load, change, overflow and standby have all happened by now
    chk(d, 32'hf);
    chk(32'(irq_o), 32'h0);
    wr(fao_pkg::OFS_MASK, 32'h1);
    chk(32'(r), 32'(fao_pkg::RESP_OKAY));
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_o), 32'h1);
    wr(fao_pkg::OFS_STATUS, 32'hf);
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_o), 32'h0);
    rd(4'h1);
    chk(32'(r), 32'(fao_pkg::RESP_SLVERR));
    $display("interrupt test done");
    wr(fao_pkg::OFS_CTRL, 32'h0);
    vin_i <= 8'h00;
    host_inst.convert(2, 3);
    repeat (6) @(posedge mclk_i);
    chk(32'({range_exceeded_flag_o, code_bit_o}), 32'(prev));
    wr(fao_pkg::OFS_CTRL, 32'h1);
    $display("freeze test done");
    for (int i = 0; i < 5; i++) begin
      {men, bits_n} <= en[i];
      repeat (6) @(posedge mclk_i);
      chk(32'({code_bit_oe_n_o, flag_oe_n_o}), 32'(ex[i]));
    end
    chk(32'(code_bit_o), 32'(prev[3:0]));
    $display("enable test done");
    stop_test;
  end
endmodule
bind fao_top fao_top_props fao_top_props_inst (.mclk_i, .rst_b_i,
  .sclk_pin_i, .code_bits_enable_n_i, .master_output_enable_i, .code_bit_o,
  .code_bit_oe_n_o, .result_changed_flag_o, .range_exceeded_flag_o,
  .flag_oe_n_o, .irq_o, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
